// [src/srwb_pkg.sv]
`default_nettype none

package srwb_pkg;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_BAUD = 8'h04;
    localparam logic [7:0] OFS_IRQ_EN = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_CLEAR = 8'h10;
    localparam logic [7:0] OFS_DATA = 8'h14;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int CTRL_SLEEP = 0;
    localparam int CTRL_BY_ADDR = 1;
    localparam int CTRL_NINE = 2;
    localparam int BAUD_PRE_LSB = 0;
    localparam int BAUD_RATE_LSB = 2;
    localparam int FLG_FULL = 0;
    localparam int FLG_OVR = 1;
    localparam int FLG_IDLE = 2;
    localparam int FLG_NOISE = 3;
    localparam int FLG_FERR = 4;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam logic [4:0] BAUD_RST = 5'h00;
    localparam logic [4:0] IRQ_EN_RST = 5'h00;
    localparam logic [4:0] FLAGS_RST = 5'h00;

    // ----------------------------------------------------------------
    // timing counts
    // ----------------------------------------------------------------
    localparam int XTAL_PER_BUS = 4;
    localparam logic [3:0] PRE_DIV_0 = 4'h1;
    localparam logic [3:0] PRE_DIV_1 = 4'h3;
    localparam logic [3:0] PRE_DIV_2 = 4'h4;
    localparam logic [3:0] PRE_DIV_3 = 4'hD;
    localparam logic [3:0] OVERSAMPLE_LAST = 4'hF;
    localparam logic [7:0] IDLE_SAMPLES_8 = 8'hA0;
    localparam logic [7:0] IDLE_SAMPLES_9 = 8'hB0;

endpackage

`default_nettype wire

// [src/srwb_baud_if.sv]
`default_nettype none

// ----------------------------------------------------------------
// baud chain control and tick carrier
// ----------------------------------------------------------------
interface srwb_baud_if;
    logic [1:0] prescale_select;
    logic [2:0] rate_select;
    logic sample_clock;
    logic bit_clock;

    modport gen (input prescale_select, input rate_select, output sample_clock, output bit_clock);
    modport user (output prescale_select, output rate_select, input sample_clock, input bit_clock);
endinterface

`default_nettype wire

// [src/srwb_baud_gen.sv]
`default_nettype none

module srwb_baud_gen #(
    parameter int STAGES = 7
) (
    input wire logic pclk,
    input wire logic presetn,
    srwb_baud_if.gen baud
);

    // elaboration check: rate select 7 taps the seventh stage
    if (STAGES < 7) begin : g_bad_stages
        $error("srwb_baud_gen: STAGES must be at least 7");
    end

    logic [3:0] pre_cnt_q, pre_cnt_d;
    logic [STAGES-1:0] chain_q, chain_d;
    logic smp_q, smp_d;
    logic [3:0] ovs_q, ovs_d;
    logic bit_q, bit_d;
    logic [3:0] pre_div;
    logic pre_tick;
    logic [STAGES-1:0] tap_mask;

    // ----------------------------------------------------------------
    // prescaler, divide-by-two chain and tap
    // ----------------------------------------------------------------
    always_comb begin
        case (baud.prescale_select)
            2'h0: pre_div = srwb_pkg::PRE_DIV_0;
            2'h1: pre_div = srwb_pkg::PRE_DIV_1;
            2'h2: pre_div = srwb_pkg::PRE_DIV_2;
            default: pre_div = srwb_pkg::PRE_DIV_3;
        endcase
        pre_tick = (pre_cnt_q >= pre_div - 4'h1);
        pre_cnt_d = pre_tick ? 4'h0 : pre_cnt_q + 4'h1;
        chain_d = pre_tick ? chain_q + 1'b1 : chain_q;
        tap_mask = STAGES'((1 << baud.rate_select) - 1);
        smp_d = pre_tick && ((chain_q & tap_mask) == tap_mask);
        ovs_d = smp_q ? ovs_q + 4'h1 : ovs_q;
        bit_d = smp_q && (ovs_q == srwb_pkg::OVERSAMPLE_LAST);
    end

    // registers of the chain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_cnt_q <= 4'h0;
            chain_q <= '0;
            smp_q <= 1'b0;
            ovs_q <= 4'h0;
            bit_q <= 1'b0;
        end else begin
            pre_cnt_q <= pre_cnt_d;
            chain_q <= chain_d;
            smp_q <= smp_d;
            ovs_q <= ovs_d;
            bit_q <= bit_d;
        end
    end

    assign baud.sample_clock = smp_q;
    assign baud.bit_clock = bit_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic [4:0] smp_since_bit_q;

    // sample ticks seen since the last bit tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            smp_since_bit_q <= 5'h00;
        end else if (bit_q) begin
            smp_since_bit_q <= 5'h00;
        end else if (smp_q) begin
            smp_since_bit_q <= smp_since_bit_q + 5'h01;
        end
    end

    a_bit_clock_div: assert property (@(posedge pclk) disable iff (!presetn)
        smp_since_bit_q <= 5'h10)
        else $error("bit clock slower than sample clock over 16");

    a_prescale_thirteen: assert property (@(posedge pclk) disable iff (!presetn)
        (pre_tick && baud.prescale_select == 2'h3 && $stable(baud.prescale_select))
        |=> !pre_tick [*8])
        else $error("divide by 13 prescaler ticked too early");

    a_fastest_tap: assert property (@(posedge pclk) disable iff (!presetn)
        (presetn && baud.prescale_select == 2'h0 && baud.rate_select == 3'h0)[*2] |-> smp_q)
        else $error("undivided tap did not tick every cycle");

endmodule // srwb_baud_gen

`default_nettype wire

// [src/srwb_rx_wakeup.sv]
`default_nettype none

module srwb_rx_wakeup #(
    parameter int DATA_W = 9
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_line,
    input wire logic rx_msb_pulse,
    input wire logic rx_msb_value,
    input wire logic frame_done,
    input wire logic [DATA_W-1:0] frame_data,
    input wire logic frame_noise,
    input wire logic frame_ferr,
    output logic nine_bit_format,
    output logic sample_clock,
    output logic bit_clock,
    output logic irq
);

    // elaboration check: the data register and its read path assume nine bits
    if (DATA_W != 9) begin : g_bad_width
        $error("srwb_rx_wakeup: DATA_W must be 9");
    end

    srwb_baud_if baud_bus();

    // the chain runs on pclk, the bus-rate clock
    srwb_baud_gen #(.STAGES(7)) u_baud (
        .pclk(pclk),
        .presetn(presetn),
        .baud(baud_bus.gen)
    );

    // ----------------------------------------------------------------
    // apb slave
    // ----------------------------------------------------------------
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    logic [31:0] prdata_q, prdata_d;
    logic [2:0] ctrl_q, ctrl_d;
    logic [4:0] baud_q, baud_d;
    logic [4:0] en_q, en_d;
    logic [4:0] flags_q, flags_d;
    logic [DATA_W-1:0] data_q, data_d;
    logic irq_q, irq_d;
    logic access, wr_now, mapped;
    logic wr_ctrl, wr_clear;

    // decode: one wait state, access completes on the second cycle
    always_comb begin
        access = psel && penable;
        wr_now = access && pready_q && pwrite;
        mapped = (paddr == srwb_pkg::OFS_CTRL) || (paddr == srwb_pkg::OFS_BAUD)
            || (paddr == srwb_pkg::OFS_IRQ_EN) || (paddr == srwb_pkg::OFS_STATUS)
            || (paddr == srwb_pkg::OFS_CLEAR) || (paddr == srwb_pkg::OFS_DATA);
        wr_ctrl = wr_now && (paddr == srwb_pkg::OFS_CTRL);
        wr_clear = wr_now && (paddr == srwb_pkg::OFS_CLEAR);
        pready_d = access && !pready_q;
        pslverr_d = access && !pready_q && !mapped;
        prdata_d = prdata_q;
        if (access && !pready_q) begin
            case (paddr)
                srwb_pkg::OFS_CTRL: prdata_d = {29'h0, ctrl_q};
                srwb_pkg::OFS_BAUD: prdata_d = {27'h0, baud_q};
                srwb_pkg::OFS_IRQ_EN: prdata_d = {27'h0, en_q};
                srwb_pkg::OFS_STATUS: prdata_d = {27'h0, flags_q};
                srwb_pkg::OFS_DATA: prdata_d = {23'h0, data_q};
                default: prdata_d = 32'h0;
            endcase
        end
    end

    // bus answer registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0;
        end else begin
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
        end
    end

    // ----------------------------------------------------------------
    // idle line detection
    // ----------------------------------------------------------------
    logic [7:0] quiet_cnt_q, quiet_cnt_d;
    logic busy_q, busy_d;
    logic quiet_event;
    logic [7:0] quiet_len;

    // count sample ticks at 1; flag only the busy-to-idle change
    always_comb begin
        quiet_len = ctrl_q[srwb_pkg::CTRL_NINE] ? srwb_pkg::IDLE_SAMPLES_9
            : srwb_pkg::IDLE_SAMPLES_8;
        quiet_cnt_d = quiet_cnt_q;
        busy_d = busy_q;
        quiet_event = 1'b0;
        if (!rx_line) begin
            quiet_cnt_d = 8'h00;
            busy_d = 1'b1;
        end else if (baud_bus.sample_clock && busy_q) begin
            if (quiet_cnt_q >= quiet_len - 8'h01) begin
                quiet_event = 1'b1;
                busy_d = 1'b0;
                quiet_cnt_d = 8'h00;
            end else begin
                quiet_cnt_d = quiet_cnt_q + 8'h01;
            end
        end
    end

    // idle detector state; the line counts as busy after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            quiet_cnt_q <= 8'h00;
            busy_q <= 1'b1;
        end else begin
            quiet_cnt_q <= quiet_cnt_d;
            busy_q <= busy_d;
        end
    end

    // ----------------------------------------------------------------
    // control, flags, data and interrupt
    // ----------------------------------------------------------------
    logic sleep_q;
    logic by_addr;
    logic wake_clr;
    logic [4:0] set_v;
    logic [4:0] irq_mask;

    assign sleep_q = ctrl_q[srwb_pkg::CTRL_SLEEP];
    assign by_addr = ctrl_q[srwb_pkg::CTRL_BY_ADDR];

    // wake-up, flag setting with set over clear, interrupt gating
    always_comb begin
        ctrl_d = ctrl_q;
        baud_d = baud_q;
        en_d = en_q;
        data_d = data_q;
        wake_clr = 1'b0;
        if (sleep_q && !by_addr && quiet_event) begin
            wake_clr = 1'b1;
        end
        if (sleep_q && by_addr && rx_msb_pulse && rx_msb_value) begin
            wake_clr = 1'b1;
        end
        if (wake_clr) begin
            ctrl_d[srwb_pkg::CTRL_SLEEP] = 1'b0;
        end
        if (wr_ctrl) begin
            ctrl_d = pwdata[2:0];
        end
        if (wr_now && paddr == srwb_pkg::OFS_BAUD) begin
            baud_d = pwdata[4:0];
        end
        if (wr_now && paddr == srwb_pkg::OFS_IRQ_EN) begin
            en_d = {2'h0, pwdata[srwb_pkg::FLG_IDLE], 1'b0, pwdata[srwb_pkg::FLG_FULL]};
        end
        set_v = 5'h00;
        if (!sleep_q) begin
            if (frame_done && flags_q[srwb_pkg::FLG_FULL]) begin
                set_v[srwb_pkg::FLG_OVR] = 1'b1;
            end else if (frame_done) begin
                set_v[srwb_pkg::FLG_FULL] = 1'b1;
                set_v[srwb_pkg::FLG_NOISE] = frame_noise;
                set_v[srwb_pkg::FLG_FERR] = frame_ferr;
                data_d = frame_data;
            end
            set_v[srwb_pkg::FLG_IDLE] = quiet_event;
        end
        flags_d = flags_q;
        if (wr_clear) begin
            flags_d = flags_q & ~pwdata[4:0];
        end
        flags_d = flags_d | set_v;
        irq_mask = {2'h0, en_d[srwb_pkg::FLG_IDLE], en_d[srwb_pkg::FLG_FULL],
            en_d[srwb_pkg::FLG_FULL]};
        irq_d = |(flags_d & irq_mask);
    end

    // control and status registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= srwb_pkg::CTRL_RST;
            baud_q <= srwb_pkg::BAUD_RST;
            en_q <= srwb_pkg::IRQ_EN_RST;
            flags_q <= srwb_pkg::FLAGS_RST;
            data_q <= '0;
            irq_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            baud_q <= baud_d;
            en_q <= en_d;
            flags_q <= flags_d;
            data_q <= data_d;
            irq_q <= irq_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign baud_bus.prescale_select = baud_q[srwb_pkg::BAUD_PRE_LSB +: 2];
    assign baud_bus.rate_select = baud_q[srwb_pkg::BAUD_RATE_LSB +: 3];
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign nine_bit_format = ctrl_q[srwb_pkg::CTRL_NINE];
    assign sample_clock = baud_bus.sample_clock;
    assign bit_clock = baud_bus.bit_clock;
    assign irq = irq_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_rx_irq_on: assert property (@(posedge pclk) disable iff (!presetn)
        (en_q[srwb_pkg::FLG_FULL] && (flags_q[srwb_pkg::FLG_FULL] || flags_q[srwb_pkg::FLG_OVR]))
        |-> irq_q)
        else $error("receive flag enabled but no interrupt");

    a_rx_irq_polled: assert property (@(posedge pclk) disable iff (!presetn)
        (!en_q[srwb_pkg::FLG_FULL]
            && !(en_q[srwb_pkg::FLG_IDLE] && flags_q[srwb_pkg::FLG_IDLE]))
        |-> !irq_q)
        else $error("interrupt while receive enable is off");

    a_idle_irq_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (en_q[srwb_pkg::FLG_IDLE] && flags_q[srwb_pkg::FLG_IDLE]) |-> irq_q)
        else $error("idle interrupt not held");

    a_idle_once: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(flags_q[srwb_pkg::FLG_IDLE]) |-> $past(quiet_event) && !busy_q)
        else $error("idle flag set without busy-to-idle change");

    a_sleep_inhibit: assert property (@(posedge pclk) disable iff (!presetn)
        sleep_q |=> ((flags_q & ~$past(flags_q)) == 5'h00))
        else $error("status flag set while asleep");

    a_idle_wake: assert property (@(posedge pclk) disable iff (!presetn)
        (sleep_q && !by_addr && quiet_event && !wr_ctrl) |=> !sleep_q)
        else $error("idle line did not wake receiver");

    a_addr_wake: assert property (@(posedge pclk) disable iff (!presetn)
        (sleep_q && by_addr && rx_msb_pulse && rx_msb_value && !wr_ctrl) |=> !sleep_q)
        else $error("address mark did not wake receiver");

    a_method_select: assert property (@(posedge pclk) disable iff (!presetn)
        (sleep_q && by_addr && !(rx_msb_pulse && rx_msb_value) && !wr_ctrl) |=> sleep_q)
        else $error("unselected method cleared sleep bit");

    a_sleep_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_ctrl |=> sleep_q == $past(pwdata[0]))
        else $error("sleep bit did not follow software write");

    a_idle_irq_off: assert property (@(posedge pclk) disable iff (!presetn)
        (!en_q[srwb_pkg::FLG_IDLE]
            && !(en_q[srwb_pkg::FLG_FULL]
            && (flags_q[srwb_pkg::FLG_FULL] || flags_q[srwb_pkg::FLG_OVR])))
        |-> !irq_q)
        else $error("idle flag requested with its enable off");

    a_rx_full_set: assert property (@(posedge pclk) disable iff (!presetn)
        (!sleep_q && frame_done && !flags_q[srwb_pkg::FLG_FULL])
        |=> flags_q[srwb_pkg::FLG_FULL] && data_q == $past(frame_data))
        else $error("awake frame not received");

    a_overrun_keep: assert property (@(posedge pclk) disable iff (!presetn)
        (!sleep_q && frame_done && flags_q[srwb_pkg::FLG_FULL])
        |=> flags_q[srwb_pkg::FLG_OVR] && $stable(data_q))
        else $error("overrun lost or overwrote data");

    a_sleep_data_hold: assert property (@(posedge pclk) disable iff (!presetn)
        sleep_q |=> $stable(data_q))
        else $error("data stored while asleep");

endmodule // srwb_rx_wakeup

`default_nettype wire

// [test/srwb_far_tx.sv]
`default_nettype none

// ----------------------------------------------------------------
// remote transmitter on the shared line, seen through the core
// ----------------------------------------------------------------
module srwb_far_tx (
    input wire logic pclk,
    output var logic rx_line,
    output var logic rx_msb_pulse,
    output var logic rx_msb_value,
    output var logic frame_done,
    output var logic [8:0] frame_data,
    output var logic frame_noise,
    output var logic frame_ferr
);
    timeunit 1ns;
    timeprecision 1ps;

    // line rests high, strobes low, qualifiers hold junk
    initial begin
        rx_line = 1'b1;
        rx_msb_pulse = 1'b0;
        rx_msb_value = 1'b1;
        frame_done = 1'b0;
        frame_data = 9'h15A;
        frame_noise = 1'b1;
        frame_ferr = 1'b1;
    end

    // one character: start, mark bit ahead of stop, done, short stop
    task automatic send(input logic [8:0] d, input logic m, input logic n, input logic f);
        @(posedge pclk) rx_line <= 1'b0;
        repeat (8) @(posedge pclk);
        rx_msb_pulse <= 1'b1;
        rx_msb_value <= m;
        @(posedge pclk);
        rx_msb_pulse <= 1'b0;
        rx_msb_value <= ~m;
        @(posedge pclk);
        frame_done <= 1'b1;
        frame_data <= d;
        frame_noise <= n;
        frame_ferr <= f;
        @(posedge pclk);
        frame_done <= 1'b0;
        frame_data <= ~d;
        frame_noise <= ~n;
        frame_ferr <= ~f;
        rx_line <= 1'b1;
        @(posedge pclk);
    endtask
endmodule // srwb_far_tx

`default_nettype wire

// [test/serial_rx_wakeup_baud_gen_test.sv]
`default_nettype none

module serial_rx_wakeup_baud_gen_test;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] a;
        logic [31:0] w;
        logic [31:0] r;
        logic e;
    } srwb_row_s;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic rx_line, rx_msb_pulse, rx_msb_value, frame_done, frame_noise, frame_ferr;
    logic [8:0] frame_data;
    logic nine_bit_format, sample_clock, bit_clock, irq;
    int errors, cmp_count, n;
    int pre [4] = '{1, 3, 4, 13};
    srwb_row_s rows [11];

    // ------------------------------------------------------------
    // design and far side
    // ------------------------------------------------------------
    srwb_rx_wakeup dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_line(rx_line),
        .rx_msb_pulse(rx_msb_pulse), .rx_msb_value(rx_msb_value),
        .frame_done(frame_done), .frame_data(frame_data), .frame_noise(frame_noise),
        .frame_ferr(frame_ferr), .nine_bit_format(nine_bit_format),
        .sample_clock(sample_clock), .bit_clock(bit_clock), .irq(irq)
    );
    srwb_far_tx far (
        .pclk(pclk), .rx_line(rx_line), .rx_msb_pulse(rx_msb_pulse),
        .rx_msb_value(rx_msb_value), .frame_done(frame_done), .frame_data(frame_data),
        .frame_noise(frame_noise), .frame_ferr(frame_ferr)
    );

    // bus clock, 40 ns period
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // count a comparison, report a mismatch
    task automatic chk(input logic ok, input string m);
        cmp_count++;
        if (ok !== 1'b1) begin
            errors++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask

    // verdict and end of run
    task automatic conclude;
        $display("errors=%0d comparisons=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // a spent wait counts as a mismatch and closes the run
    task automatic tmo(input logic spent);
        if (spent) begin
            chk(1'b0, "wait timed out");
            conclude();
        end
    endtask

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        tmo(pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // read and compare one register
    task automatic rchk(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(rd === x && er === 1'b0, $sformatf("read at %h", a));
    endtask

    // interrupt level a little after its cause
    task automatic ckirq(input logic x);
        repeat (2) @(posedge pclk);
        chk(irq === x, "irq level");
    endtask

    // cycles between the second and third pulse of a tick output
    task automatic per(input logic b);
        for (int j = 0; j < 3; j++) begin
            n = 0;
            do begin
                @(posedge pclk);
                n++;
            end while ((b ? bit_clock : sample_clock) !== 1'b1 && n < 30000);
        end
        tmo(n >= 30000);
    endtask

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        errors = 0;
        cmp_count = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        rows = '{'{8'h00, 32'h6, 32'h6, 1'b0}, '{8'h00, 32'h1, 32'h1, 1'b0},
            '{8'h00, 32'hFFFFFFF8, 32'h0, 1'b0}, '{8'h04, 32'h1F, 32'h1F, 1'b0},
            '{8'h04, 32'h0, 32'h0, 1'b0}, '{8'h08, 32'hFF, 32'h5, 1'b0},
            '{8'h08, 32'h0, 32'h0, 1'b0}, '{8'h0C, 32'hFF, 32'h0, 1'b0},
            '{8'h10, 32'h1F, 32'h0, 1'b0}, '{8'h14, 32'hFF, 32'h0, 1'b0},
            '{8'h18, 32'hFF, 32'h0, 1'b1}};
        repeat (10) @(posedge pclk);
        chk(irq === 1'b0 && pready === 1'b0 && sample_clock === 1'b0, "reset outputs");
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 6; i++) rchk(8'(4 * i), 32'h0);
        repeat (200) @(posedge pclk);
        apb(1'b1, srwb_pkg::OFS_CLEAR, 32'h1F);
        // register access table
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].w);
            apb(1'b0, rows[i].a, 32'h0);
            chk(rd === rows[i].r && er === rows[i].e, "row readback");
        end
        // receive flags and their request enable
        far.send(9'h055, 1'b0, 1'b1, 1'b1);
        ckirq(1'b0);
        rchk(srwb_pkg::OFS_STATUS, 32'h19);
        apb(1'b1, srwb_pkg::OFS_IRQ_EN, 32'h1);
        ckirq(1'b1);
        far.send(9'h0AA, 1'b1, 1'b0, 1'b0);
        rchk(srwb_pkg::OFS_DATA, 32'h55);
        rchk(srwb_pkg::OFS_STATUS, 32'h1B);
        apb(1'b1, srwb_pkg::OFS_CLEAR, 32'h19);
        ckirq(1'b1);
        apb(1'b1, srwb_pkg::OFS_CLEAR, 32'h2);
        ckirq(1'b0);
        // idle detection and its request enable
        repeat (200) @(posedge pclk);
        apb(1'b1, srwb_pkg::OFS_CLEAR, 32'h1F);
        apb(1'b1, srwb_pkg::OFS_IRQ_EN, 32'h4);
        far.send(9'h001, 1'b0, 1'b0, 1'b0);
        repeat (100) @(posedge pclk);
        ckirq(1'b0);
        repeat (100) @(posedge pclk);
        ckirq(1'b1);
        rchk(srwb_pkg::OFS_STATUS, 32'h5);
        apb(1'b1, srwb_pkg::OFS_IRQ_EN, 32'h0);
        ckirq(1'b0);
        apb(1'b1, srwb_pkg::OFS_IRQ_EN, 32'h4);
        ckirq(1'b1);
        apb(1'b1, srwb_pkg::OFS_CLEAR, 32'h1F);
        repeat (200) @(posedge pclk);
        ckirq(1'b0);
        // idle-line wake-up
        apb(1'b1, srwb_pkg::OFS_IRQ_EN, 32'h5);
        apb(1'b1, srwb_pkg::OFS_CTRL, 32'h1);
        far.send(9'h0F0, 1'b1, 1'b1, 1'b1);
        far.send(9'h0F1, 1'b1, 1'b0, 1'b0);
        rchk(srwb_pkg::OFS_CTRL, 32'h1);
        rchk(srwb_pkg::OFS_STATUS, 32'h0);
        ckirq(1'b0);
        repeat (200) @(posedge pclk);
        rchk(srwb_pkg::OFS_CTRL, 32'h0);
        rchk(srwb_pkg::OFS_STATUS, 32'h0);
        far.send(9'h012, 1'b0, 1'b0, 1'b0);
        rchk(srwb_pkg::OFS_STATUS, 32'h1);
        rchk(srwb_pkg::OFS_DATA, 32'h12);
        // address-mark wake-up
        repeat (200) @(posedge pclk);
        apb(1'b1, srwb_pkg::OFS_CLEAR, 32'h1F);
        apb(1'b1, srwb_pkg::OFS_CTRL, 32'h3);
        far.send(9'h011, 1'b0, 1'b1, 1'b1);
        repeat (200) @(posedge pclk);
        rchk(srwb_pkg::OFS_CTRL, 32'h3);
        rchk(srwb_pkg::OFS_STATUS, 32'h0);
        far.send(9'h0A1, 1'b1, 1'b0, 1'b0);
        rchk(srwb_pkg::OFS_CTRL, 32'h2);
        rchk(srwb_pkg::OFS_STATUS, 32'h1);
        rchk(srwb_pkg::OFS_DATA, 32'hA1);
        // address marks in the nine-bit format
        apb(1'b1, srwb_pkg::OFS_CLEAR, 32'h1F);
        apb(1'b1, srwb_pkg::OFS_CTRL, 32'h7);
        chk(nine_bit_format === 1'b1, "nine-bit output");
        far.send(9'h0A2, 1'b0, 1'b0, 1'b0);
        rchk(srwb_pkg::OFS_CTRL, 32'h7);
        far.send(9'h1A5, 1'b1, 1'b0, 1'b0);
        rchk(srwb_pkg::OFS_CTRL, 32'h6);
        rchk(srwb_pkg::OFS_DATA, 32'h1A5);
        // nine-bit idle takes 176 sample ticks, not 160
        apb(1'b1, srwb_pkg::OFS_CLEAR, 32'h1F);
        far.send(9'h003, 1'b0, 1'b0, 1'b0);
        repeat (160) @(posedge pclk);
        rchk(srwb_pkg::OFS_STATUS, 32'h1);
        repeat (20) @(posedge pclk);
        rchk(srwb_pkg::OFS_STATUS, 32'h5);
        apb(1'b1, srwb_pkg::OFS_CTRL, 32'h0);
        // baud chain divide and tap for every setting
        for (int p = 0; p < 4; p++) begin
            for (int r = 0; r < 8; r++) begin
                apb(1'b1, srwb_pkg::OFS_BAUD, {27'h0, 3'(r), 2'(p)});
                per(1'b0);
                chk(n == (pre[p] << r), "sample period");
            end
            apb(1'b1, srwb_pkg::OFS_BAUD, {30'h0, 2'(p)});
            per(1'b1);
            chk(n == 16 * pre[p], "bit period");
            @(posedge pclk);
            chk(bit_clock === 1'b0, "bit pulse width");
        end
        conclude();
    end
endmodule // serial_rx_wakeup_baud_gen_test

`default_nettype wire
